// >>> flash_bus_cycle.sv
`timescale 1ns/100ps
// One read or write cycle on the asynchronous flash bus.
module flash_bus_cycle
	import flash_status_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Request.
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	// Pins.
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic [DATA_W-1:0] i_dq
);
	typedef enum logic [2:0] {
		C_IDLE = 3'h1,
		C_STROBE = 3'h2,
		C_GAP = 3'h4
	} cyc_t;
	cyc_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic wr_reg;

	// Each cycle drops CE with OE or WE, so every status read is a distinct read cycle.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= C_IDLE;
			cnt_reg <= '0;
			wr_reg <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= '0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= '0;
			o_dq <= '0;
			o_dq_oe <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (state_reg)
				C_IDLE: begin
					if (i_start) begin
						state_reg <= C_STROBE;
						cnt_reg <= CNT_W'(READ_CYCLES);
						wr_reg <= i_write;
						o_addr <= i_addr;
						o_dq <= i_wdata;
						o_dq_oe <= i_write;
						o_ce_n <= 1'b0;
						o_oe_n <= i_write;
						o_we_n <= ~i_write;
					end
				end
				C_STROBE: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == '0) begin
						// Sample before OE rises; the final edge ends the cycle.
						if (!wr_reg) o_rdata <= i_dq;
						o_ce_n <= 1'b1;
						o_oe_n <= 1'b1;
						o_we_n <= 1'b1;
						cnt_reg <= CNT_W'(GAP_CYCLES);
						state_reg <= C_GAP;
					end
				end
				C_GAP: begin
					cnt_reg <= cnt_reg - 1'b1;
					if (cnt_reg == '0) begin
						o_dq_oe <= 1'b0;
						o_done <= 1'b1;
						state_reg <= C_IDLE;
					end
				end
			endcase
		end
	end
endmodule // flash_bus_cycle

// >>> flash_dev_model.sv
`timescale 1ns/100ps
// Behavioural flash bank answering status reads.
module flash_dev_model
	import flash_status_pkg::*;
(
	// Bench control.
	input wire logic i_clk,
	input wire logic i_load,
	input wire logic [7:0] i_reads,
	input wire logic i_fail,
	input wire logic i_win,
	// Flash pins.
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0] o_dq,
	output logic o_ready_busy_out_n
);
	logic [7:0] left_reg;
	logic tog_reg, fail_reg, win_reg, oe_reg, busy;
	logic [DATA_W-1:0] stat;
	// Status while busy, array data when not; a released bus shows the inverse.
	assign busy = left_reg != 0 || fail_reg;
	assign stat = busy ? {1'b0, tog_reg, fail_reg, 1'b0, win_reg, tog_reg, 2'h0} : 8'h5a;
	assign o_dq = i_oe_n ? ~stat : stat;
	assign o_ready_busy_out_n = !busy;
	// A finished read flips both toggle bits; a failed job only ends on reset command.
	always_ff @(posedge i_clk) begin
		oe_reg <= i_oe_n;
		if (i_load) begin
			// A job of n reads stands for a protected or suspend-mode job that ends by itself.
			{left_reg, fail_reg, win_reg, tog_reg} <= {i_reads, i_fail, i_win, 1'b0};
		end else if (!i_we_n && i_dq == RESET_CMD && (fail_reg || !win_reg)) begin
			{left_reg, fail_reg} <= '0;
		end else if (i_oe_n && !oe_reg && busy) begin
			tog_reg <= ~tog_reg;
			left_reg <= left_reg - 8'(!fail_reg);
		end
	end
endmodule // flash_dev_model

// >>> flash_status_pkg.sv
// Constants for the host-side flash write-status poller.
package flash_status_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	// Status byte bit positions.
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int LIMIT_BIT = 5;
	localparam int WINDOW_BIT = 3;
	localparam int SECTOR_TOGGLE_BIT = 2;
	// Read cycle timing at 200 MHz.
	localparam int CLK_NS = 5;
	localparam int READ_ACCESS_NS = 70;
	localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_GAP_NS = 20;
	localparam int GAP_CYCLES = (STROBE_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 5;
	localparam logic [7:0] RESET_CMD = 8'hf0;
	// Poll outcomes.
	localparam logic [1:0] RES_DONE = 2'h0;
	localparam logic [1:0] RES_FAIL = 2'h1;
	localparam logic [1:0] RES_WINDOW_SHUT = 2'h2;
endpackage

// >>> flash_status_poller.sv
`timescale 1ns/100ps
// Host controller that polls a flash bank's write-operation status byte.
module flash_status_poller
	import flash_status_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// User orders.
	input wire logic i_poll_start,
	input wire logic i_window_check,
	input wire logic [ADDR_W-1:0] i_status_addr,
	input wire logic i_abort,
	// User answers.
	output logic o_busy,
	output logic o_result_valid,
	output logic [1:0] o_result,
	output logic [DATA_W-1:0] o_last_status,
	output logic o_device_ready,
	// Flash pins.
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic [DATA_W-1:0] i_dq,
	input wire logic i_ready_busy_out_n
);
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_READ1 = 7'h02,
		S_READ2 = 7'h04,
		S_RECHECK = 7'h08,
		S_RESET_CMD = 7'h10,
		S_WINDOW = 7'h20,
		S_ANSWER = 7'h40
	} poll_t;
	poll_t state_reg;
	logic first_reg;
	logic limit_seen_reg;
	logic [1:0] res_reg;
	logic cyc_start_reg;
	logic cyc_write_reg;
	logic [ADDR_W-1:0] stat_addr_reg;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;

	// Decoding of the returned status byte.
	function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		return a[TOGGLE_BIT] ^ b[TOGGLE_BIT];
	endfunction
	wire logic still_toggling = toggled(o_last_status, cyc_rdata);
	wire logic limit_high = cyc_rdata[LIMIT_BIT];
	wire logic window_shut = cyc_rdata[WINDOW_BIT];

	flash_bus_cycle u_cycle (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_start(cyc_start_reg),
		.i_write(cyc_write_reg),
		.i_addr(stat_addr_reg),
		.i_wdata(RESET_CMD),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n),
		.o_addr(o_addr),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe),
		.i_dq(i_dq)
	);

	// Ready/busy pin is sampled as a plain level; low means the algorithm runs.
	always_ff @(posedge i_clk) begin
		if (i_rst) o_device_ready <= 1'b1;
		else o_device_ready <= i_ready_busy_out_n;
	end

	// Poll sequencer; a poll order from idle begins with a fresh double read, a window check with a single read.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= S_IDLE;
			first_reg <= 1'b0;
			limit_seen_reg <= 1'b0;
			res_reg <= RES_DONE;
			cyc_start_reg <= 1'b0;
			cyc_write_reg <= 1'b0;
			stat_addr_reg <= '0;
			o_busy <= 1'b0;
			o_result_valid <= 1'b0;
			o_result <= RES_DONE;
			o_last_status <= '0;
		end else begin
			cyc_start_reg <= 1'b0;
			o_result_valid <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					if (i_poll_start || i_window_check) begin
						// Address must be in the busy bank and a valid location.
						stat_addr_reg <= i_status_addr;
						cyc_write_reg <= 1'b0;
						cyc_start_reg <= 1'b1;
						o_busy <= 1'b1;
						limit_seen_reg <= 1'b0;
						// A window check is optional: a user who can keep extra erases close may skip it.
						state_reg <= i_window_check ? S_WINDOW : S_READ1;
					end
				end
				S_WINDOW: begin
					if (cyc_done) begin
						// Read around each extra sector erase to see if the window shut.
						o_last_status <= cyc_rdata;
						res_reg <= window_shut ? RES_WINDOW_SHUT : RES_DONE;
						state_reg <= S_ANSWER;
					end
				end
				S_READ1: begin
					if (cyc_done) begin
						o_last_status <= cyc_rdata;
						cyc_start_reg <= 1'b1;
						state_reg <= S_READ2;
					end
				end
				S_READ2, S_RECHECK: begin
					if (cyc_done) begin
						o_last_status <= cyc_rdata;
						if (!still_toggling) begin
							res_reg <= RES_DONE;
							state_reg <= S_ANSWER;
						end else if (state_reg == S_RECHECK) begin
							// Still toggling after the limit flag rose: failed.
							res_reg <= RES_FAIL;
							cyc_write_reg <= 1'b1;
							cyc_start_reg <= 1'b1;
							state_reg <= S_RESET_CMD;
						end else begin
							// Recheck once more when limit is high; otherwise keep polling.
							cyc_start_reg <= 1'b1;
							state_reg <= limit_high ? S_RECHECK : S_READ2;
						end
					end else if (i_abort && state_reg == S_READ2) begin
						first_reg <= 1'b1;
					end
					if (first_reg && cyc_done) begin
						// Host leaves polling; next order starts from the top.
						first_reg <= 1'b0;
						cyc_start_reg <= 1'b0;
						o_busy <= 1'b0;
						state_reg <= S_IDLE;
					end
				end
				S_RESET_CMD: begin
					if (cyc_done) begin
						cyc_write_reg <= 1'b0;
						state_reg <= S_ANSWER;
					end
				end
				S_ANSWER: begin
					o_result <= res_reg;
					o_result_valid <= 1'b1;
					o_busy <= 1'b0;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // flash_status_poller

// >>> flash_status_poller_asserts.sv
`timescale 1ns/100ps
// Port checker for the status poller.
module flash_status_poller_asserts
	import flash_status_pkg::*;
(
	// Watched ports.
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic o_busy,
	input wire logic o_result_valid,
	input wire logic [1:0] o_result,
	input wire logic [DATA_W-1:0] o_last_status,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic [ADDR_W-1:0] o_addr,
	input wire logic [DATA_W-1:0] o_dq,
	input wire logic o_dq_oe
);
	// One clock domain, so one clocking and one disable serve all.
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_no_fight: assert property (!o_oe_n |-> !o_dq_oe)
		else $error("host drives dq in a read");
	a_reset_cmd: assert property (!o_we_n |-> o_dq_oe && o_dq == RESET_CMD)
		else $error("write is not the reset command");
	a_addr_hold: assert property (!o_oe_n && $past(!o_oe_n) |-> $stable(o_addr))
		else $error("address moved in a read");
	a_read_len: assert property ($fell(o_oe_n) |-> !o_oe_n [*8])
		else $error("read strobe too short");
	a_read_first: assert property ($rose(o_busy) |-> ##[0:3] !o_oe_n)
		else $error("order did not start a read");
	a_fail_limit: assert property (o_result_valid && o_result == RES_FAIL
		|-> o_last_status[LIMIT_BIT])
		else $error("fail without limit flag");
	a_window_res: assert property (o_result_valid && o_result == RES_WINDOW_SHUT
		|-> o_last_status[WINDOW_BIT])
		else $error("window shut without flag");
	a_pulse_once: assert property (o_result_valid |=> !o_result_valid)
		else $error("result pulse too long");
endmodule // flash_status_poller_asserts
bind flash_status_poller flash_status_poller_asserts flash_status_poller_asserts_inst (
	.i_clk, .i_rst, .o_busy, .o_result_valid, .o_result, .o_last_status,
	.o_oe_n, .o_we_n, .o_addr, .o_dq, .o_dq_oe);

// >>> tb.sv
`timescale 1ns/100ps
// Self-checking bench for the status poller.
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
	import flash_status_pkg::*;
	logic i_clk = 0, i_rst = 1, i_poll_start = 0, i_window_check = 0, i_abort = 0;
	logic [ADDR_W-1:0] i_status_addr = '0;
	logic ld = 0, fl = 0, wn = 0, o_busy, o_result_valid, o_device_ready;
	logic ce_n, oe_n, we_n, dq_oe, rb_n;
	logic [ADDR_W-1:0] addr_h;
	logic [7:0] nr = 0;
	logic [1:0] o_result, res;
	logic [DATA_W-1:0] o_last_status, dq_h, dq_d;
	int miscompares = 0, n_checks = 0, seed = 32'hb7be71ef, k;
	wire [DATA_W-1:0] dq_w = dq_oe ? dq_h : dq_d;
	flash_status_poller flash_status_poller_inst (.i_clk, .i_rst, .i_poll_start,
		.i_window_check, .i_status_addr, .i_abort, .o_busy, .o_result_valid, .o_result,
		.o_last_status, .o_device_ready, .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_addr(addr_h), .o_dq(dq_h), .o_dq_oe(dq_oe), .i_dq(dq_w), .i_ready_busy_out_n(rb_n));
	flash_dev_model flash_dev_model_inst (.i_clk, .i_load(ld), .i_reads(nr), .i_fail(fl),
		.i_win(wn), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq_h), .o_dq(dq_d),
		.o_ready_busy_out_n(rb_n));
	// Free-running clock.
	initial forever #2.5 i_clk = ~i_clk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Sets up the bank's job and checks the ready line follows it.
	task automatic load(input logic [7:0] n, input logic f, input logic w);
		@(posedge i_clk);
		{ld, nr, fl, wn} <= {1'b1, n, f, w};
		@(posedge i_clk);
		ld <= 0;
		repeat (2) @(posedge i_clk);
		`CHK("ready", n == 0 && !f, o_device_ready)
	endtask
	// Issues one order and waits, bounded, for its result.
	task automatic order(input logic win);
		@(posedge i_clk);
		{i_poll_start, i_window_check} <= {!win, win};
		@(posedge i_clk);
		{i_poll_start, i_window_check} <= 2'h0;
		for (k = 0; k < 4000 && o_result_valid !== 1'b1; k++) @(posedge i_clk);
		if (k == 4000) begin
			miscompares++;
			print_verdict();
		end
		res = o_result;
		`CHK("addr", i_status_addr, addr_h)
		`CHK("ce idle", 1'b1, ce_n)
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 0;
		i_status_addr <= ADDR_W'($random(seed));
		// Random job lengths, the zero case first.
		for (int j = 0; j < 6; j++) begin
			load(j == 0 ? 8'h0 : 8'($unsigned($random(seed)) % 6), 0, 0);
			order(0);
			`CHK("done", RES_DONE, res)
			`CHK("data", 8'h5a, o_last_status)
		end
		// Job that overran its limit keeps toggling.
		load(50, 1, 0);
		order(0);
		`CHK("fail", RES_FAIL, res)
		repeat (3) @(posedge i_clk);
		`CHK("recovered", 1'b1, o_device_ready)
		// Window flag low then high.
		for (int w = 0; w < 2; w++) begin
			load(50, 0, w[0]);
			order(1);
			`CHK("window", w ? RES_WINDOW_SHUT : RES_DONE, res)
		end
		// Leave polling mid-job, then start again from a fresh double read.
		load(200, 0, 0);
		{i_poll_start, k} <= 0;
		@(posedge i_clk);
		i_poll_start <= 1;
		@(posedge i_clk);
		i_poll_start <= 0;
		repeat (40) @(posedge i_clk);
		i_abort <= 1;
		for (k = 0; k < 200 && o_busy; k++) begin
			@(posedge i_clk);
			`CHK("no result", 1'b0, o_result_valid)
		end
		i_abort <= 0;
		`CHK("left", 1'b0, o_busy)
		load(3, 0, 0);
		order(0);
		`CHK("restart", RES_DONE, res)
		print_verdict();
	end
endmodule // tb
